//--- hdl/sadc_sequencer.v
// Successive-approximation converter sequencer with register port
// What this block does
// - Analog circuitry is powered only while the power-on bit is set.
// - Select codes 0-7 pick an analog input, code 15 the band-gap.
// - Writing one to busy bit 6 starts conversion; zero does nothing.
// - Busy bit reads one during the whole conversion, zero when idle.
// - On completion clear busy, set done bit 7, request interrupt if enabled.
// - Result upper 8 bits to high register, lowest 2 bits to low register.
// - Done flag stays until software clears it; no new conversion meanwhile.
// - With external trigger selected, a pin falling edge starts a conversion.
// - Start requests during a conversion are silently dropped.
// - Acquisition lasts one plus sample-time setting cycles, 1 to 256.
// - Comparator checks the result against a 10-bit constant in two registers.
// - With compare enabled, compare output updates at every completion.
// - Polarity 0: output one if result >= constant; 1: if result below.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_defines.vh"
module sadc_sequencer #(
   parameter SAR_STEPS = `SADC_SAR_STEPS
) (
   input wire clk,
   input wire nrst,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire trigger_pin,
   output reg analog_power,
   output reg [8:0] analog_input_en,
   output reg sample_hold,
   output reg [9:0] sar_trial,
   input wire sar_compare,
   output wire irq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_ACQ = 2'd1;
   localparam ST_SAR = 2'd2;

   reg [1:0] state;
   reg [7:0] acq_cnt;
   reg [3:0] step;
   reg [9:0] sar_val;
   reg [9:0] result;
   reg done_flag;
   reg [3:0] input_select;
   reg converter_power_on;
   reg external_trigger_select;
   reg [2:0] clk_div_field;
   reg compare_polarity;
   reg compare_enable;
   reg compare_output;
   reg [7:0] sample_time_setting;
   reg [7:0] compare_value_high;
   reg [1:0] compare_value_low;
   reg [1:0] irq_status;
   reg [1:0] irq_mask;
   wire pin_fall;
   wire busy;
   wire sw_start;
   wire start;
   wire finish;
   wire [9:0] compare_value;
   wire [1:0] irq_set;
   wire rd_stat;
   wire acq_more;
   wire [9:0] final_value;
   wire cmp_hit;
   wire [8:0] route_hit;
   genvar ch;

   function sel_hit;
      input [7:0] a;
      input [7:0] off;
      begin
         sel_hit = (a == off);
      end
   endfunction

   function route_match;
      input [3:0] sel;
      input integer code;
      begin
         route_match = ({28'h0000000, sel} == code);
      end
   endfunction

   sadc_edge_sync u_sync (
      .clk(clk),
      .nrst(nrst),
      .pin(trigger_pin),
      .fall(pin_fall)
   );

   assign busy = (state != ST_IDLE);
   assign sw_start = wr && sel_hit(addr, `SADC_OFF_CTRL0) && wdata[`SADC_BIT_BUSY];
   // gate both sources; done flag blocks, busy discards
   assign start = (sw_start || (external_trigger_select && pin_fall)) && !busy
      && !done_flag && converter_power_on;
   assign finish = (state == ST_SAR) && (step == SAR_STEPS[3:0] - 4'd1);
   assign compare_value = {compare_value_high, compare_value_low};
   assign rd_stat = rd && sel_hit(addr, `SADC_OFF_IRQ_STAT);
   assign irq_set = {finish && compare_enable, finish};
   assign irq = |(irq_status & irq_mask);
   assign acq_more = (state == ST_ACQ) && (acq_cnt != 8'h00) && converter_power_on;
   assign final_value = sar_compare ? sar_trial : sar_val;
   assign cmp_hit = compare_polarity ? (final_value < compare_value)
      : (final_value >= compare_value);

   generate
      for (ch = 0; ch < 8; ch = ch + 1) begin : g_route
         assign route_hit[ch] = route_match(input_select, ch);
      end
   endgenerate
   assign route_hit[8] = (input_select == `SADC_SEL_BANDGAP);

   // Trial word: bits already decided plus the bit under test
   always @* begin
      sar_trial = sar_val | (10'h200 >> step);
      if (state != ST_SAR) begin
         sar_trial = 10'h000;
      end
   end

   // one-hot input routing, reserved codes route nothing
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analog_power <= 1'b0;
         analog_input_en <= 9'h000;
         sample_hold <= 1'b0;
      end else begin
         analog_power <= converter_power_on;
         // Reserved codes match no channel
         analog_input_en <= converter_power_on ? route_hit : 9'h000;
         // Exactly as long as acquisition, so no trial overlaps sampling
         sample_hold <= start || acq_more;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         acq_cnt <= 8'h00;
         step <= 4'h0;
         sar_val <= 10'h000;
         result <= 10'h000;
         compare_output <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  state <= ST_ACQ;
                  acq_cnt <= sample_time_setting;
               end
            end
            ST_ACQ: begin
               if (acq_cnt == 8'h00) begin
                  state <= ST_SAR;
                  step <= 4'h0;
                  sar_val <= 10'h000;
               end else begin
                  acq_cnt <= acq_cnt - 8'h01;
               end
            end
            ST_SAR: begin
               if (sar_compare) begin
                  sar_val <= sar_trial;
               end
               step <= step + 4'h1;
               if (finish) begin
                  state <= ST_IDLE;
                  // store full result, split on read
                  result <= final_value;
                  if (compare_enable) begin
                     compare_output <= cmp_hit;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
         // Power removal aborts a conversion
         if (!converter_power_on) begin
            state <= ST_IDLE;
         end
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_flag <= 1'b0;
         input_select <= 4'h0;
         converter_power_on <= 1'b0;
         external_trigger_select <= 1'b0;
         clk_div_field <= 3'h2;
         compare_polarity <= 1'b0;
         compare_enable <= 1'b0;
         sample_time_setting <= `SADC_SAMPLE_RESET;
         compare_value_high <= 8'h00;
         compare_value_low <= 2'h0;
         irq_status <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         if (wr) begin
            if (sel_hit(addr, `SADC_OFF_CTRL0)) begin
               done_flag <= wdata[`SADC_BIT_DONE];
               input_select <= wdata[`SADC_SEL_MSB:0];
            end
            if (sel_hit(addr, `SADC_OFF_CTRL1)) begin
               converter_power_on <= wdata[`SADC_BIT_POWER];
               external_trigger_select <= wdata[`SADC_BIT_EXT];
               clk_div_field <= wdata[6:4];
            end
            if (sel_hit(addr, `SADC_OFF_CTRL2)) begin
               compare_polarity <= wdata[`SADC_BIT_CMP_POL];
               compare_enable <= wdata[`SADC_BIT_CMP_EN];
            end
            if (sel_hit(addr, `SADC_OFF_SAMPLE)) begin
               sample_time_setting <= wdata;
            end
            if (sel_hit(addr, `SADC_OFF_CMP_HI)) begin
               compare_value_high <= wdata;
            end
            if (sel_hit(addr, `SADC_OFF_CMP_LO)) begin
               compare_value_low <= wdata[1:0];
            end
            if (sel_hit(addr, `SADC_OFF_IRQ_MASK)) begin
               irq_mask <= wdata[1:0];
            end
         end
         // completion sets done, set beats clear
         if (finish) begin
            done_flag <= 1'b1;
         end
         // Read clears status; a same-cycle event survives
         irq_status <= (rd_stat ? 2'h0 : irq_status) | irq_set;
      end
   end

   // Read data valid in the cycle after the strobe
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `SADC_OFF_CTRL0: rdata <= {done_flag, busy, 2'b00, input_select};
            `SADC_OFF_CTRL1: rdata <= {1'b0, clk_div_field, 2'b00, external_trigger_select,
               converter_power_on};
            `SADC_OFF_CTRL2: rdata <= {1'b0, compare_polarity, compare_enable, compare_output,
               4'h0};
            `SADC_OFF_SAMPLE: rdata <= sample_time_setting;
            `SADC_OFF_RES_HI: rdata <= result[9:2];
            `SADC_OFF_RES_LO: rdata <= {6'h00, result[1:0]};
            `SADC_OFF_CMP_HI: rdata <= compare_value_high;
            `SADC_OFF_CMP_LO: rdata <= {6'h00, compare_value_low};
            `SADC_OFF_IRQ_STAT: rdata <= {6'h00, irq_status};
            `SADC_OFF_IRQ_MASK: rdata <= {6'h00, irq_mask};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule // sadc_sequencer

//--- common/sadc_defines.vh
// Register offsets, field positions, reset values and timing for the converter sequencer
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH
`define SADC_ADDR_W 8
`define SADC_OFF_CTRL0 8'hE8
`define SADC_OFF_CTRL1 8'hE1
`define SADC_OFF_CTRL2 8'hE2
`define SADC_OFF_SAMPLE 8'hF2
`define SADC_OFF_RES_HI 8'hC3
`define SADC_OFF_RES_LO 8'hC2
`define SADC_OFF_CMP_HI 8'hF0
`define SADC_OFF_CMP_LO 8'hF1
`define SADC_OFF_IRQ_STAT 8'hF4
`define SADC_OFF_IRQ_MASK 8'hF5
`define SADC_CTRL0_RESET 8'h00
`define SADC_CTRL1_RESET 8'h20
`define SADC_CTRL2_RESET 8'h00
`define SADC_SAMPLE_RESET 8'h00
`define SADC_BIT_DONE 7
`define SADC_BIT_BUSY 6
`define SADC_SEL_MSB 3
`define SADC_BIT_POWER 0
`define SADC_BIT_EXT 1
`define SADC_BIT_CMP_POL 6
`define SADC_BIT_CMP_EN 5
`define SADC_BIT_CMP_OUT 4
`define SADC_IRQ_DONE 0
`define SADC_IRQ_CMP 1
`define SADC_SEL_MAX_AIN 4'h7
`define SADC_SEL_BANDGAP 4'hF
`define SADC_SAR_STEPS 10
`endif

//--- hdl/sadc_edge_sync.v
// Two-stage synchroniser with falling-edge detector for the trigger pin
`timescale 1ns/100ps
module sadc_edge_sync (
   input wire clk,
   input wire nrst,
   input wire pin,
   output reg fall
);
   reg meta;
   reg sync;
   reg sync_d;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         sync_d <= 1'b1;
         fall <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         sync_d <= sync;
         fall <= sync_d & ~sync;
      end
   end
endmodule // sadc_edge_sync

//--- tb/sadc_sequencer_assertions.sv
// Port-level checks for the converter sequencer
`timescale 1ns/100ps
module sadc_sequencer_assertions #(
   parameter SAR_STEPS = 10
) (
   input wire clk,
   input wire nrst,
   input wire [7:0] addr,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire analog_power,
   input wire [8:0] analog_input_en,
   input wire sample_hold,
   input wire [9:0] sar_trial,
   input wire irq
);
   localparam int SAR_MAX = SAR_STEPS + 1;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sel_onehot_a: assert property ($onehot0(analog_input_en))
      else $error("several inputs routed");
   power_off_a: assert property (!analog_power && !$past(analog_power) |-> !analog_input_en)
      else $error("input routed while unpowered");
   trial_excl_a: assert property (sample_hold |-> sar_trial == 10'h000)
      else $error("trial during acquisition");
   sample_len_a: assert property ($rose(sample_hold) |-> ##[1:256] !sample_hold)
      else $error("acquisition too long");
   sar_len_a: assert property ($rose(|sar_trial) |-> ##[1:SAR_MAX] sar_trial == 10'h000)
      else $error("approximation too long");
   irq_cause_a: assert property ($rose(irq) |-> $past(|sar_trial) || $past(|sar_trial, 2) || $past(wr))
      else $error("interrupt without cause");
   rdata_quiet_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read");
   unmapped_read_a: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   cover property ($rose(irq));
   cover property ($rose(sample_hold));
   cover property (analog_input_en[8]);
endmodule // sadc_sequencer_assertions
bind sadc_sequencer sadc_sequencer_assertions #(.SAR_STEPS(SAR_STEPS)) u_chk (.clk(clk),
   .nrst(nrst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .analog_power(analog_power),
   .analog_input_en(analog_input_en), .sample_hold(sample_hold), .sar_trial(sar_trial), .irq(irq));

//--- tb/sadc_analog_model.sv
// Behavioural analog front end answering approximation trials
`timescale 1ns/100ps
module sadc_analog_model (
   input wire clk,
   input wire analog_power,
   input wire [9:0] sar_trial,
   input wire [9:0] level,
   output reg sar_compare
);
   reg flip = 1'b0;
   always @(posedge clk) flip <= ~flip;
   // keep bit when unpowered output is junk
   always @* sar_compare = analog_power ? (sar_trial <= level) : flip;
endmodule // sadc_analog_model

//--- tb/sadc_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sadc_sequencer_bench;
   reg clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b1, rd_q = 1'b0;
   reg [7:0] addr = 8'h00, wdata = 8'h00;
   reg [9:0] lvl = 10'h000, cmpv = 10'h000;
   reg [15:0] run = 16'h0000, acq_n = 16'h0000;
   reg [31:0] seed = 32'h26E6AD5A;
   reg [15:0] exp_q[$];
   integer num_errors = 0, n_compared = 0, cyc = 0, k;
   wire [7:0] rdata;
   wire [8:0] ain_en;
   wire [9:0] trial;
   wire pwr, hold, cmp, irq;
   always #2 clk = ~clk;
   sadc_sequencer dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .trigger_pin(pin), .analog_power(pwr), .analog_input_en(ain_en),
      .sample_hold(hold), .sar_trial(trial), .sar_compare(cmp), .irq(irq));
   sadc_analog_model far (.clk(clk), .analog_power(pwr), .sar_trial(trial), .level(lvl),
      .sar_compare(cmp));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [31:0] got, input [31:0] want);
      n_compared = n_compared + 1;
      if (got !== want) begin
         num_errors = num_errors + 1;
         $display("ERROR at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task end_of_test;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Mask marks the bits that the read must match
   task rd_reg(input [7:0] a, input [7:0] m, input [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back({m, e & m});
      @(posedge clk);
      rd <= 1'b0;
   endtask
   always @(posedge clk) begin
      rd_q <= rd;
      cyc = cyc + 1;
      run <= hold ? run + 16'h0001 : 16'h0000;
      if (!hold && run != 16'h0000) acq_n <= run;
      if (rd_q) begin
         chk(rdata & exp_q[0][15:8], exp_q[0][7:0]);
         exp_q.delete(0);
      end
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
   end
   task conv(input [3:0] sel, input [7:0] st, input ext, input pol);
      integer i;
      seed = lfsr(seed);
      lvl = seed[9:0];
      cmpv = seed[10] ? lvl : lvl + 10'h001;
      wr_reg(8'hE1, {6'h00, ext, 1'b1});
      wr_reg(8'hF2, st);
      wr_reg(8'hF0, cmpv[9:2]);
      wr_reg(8'hF1, {6'h00, cmpv[1:0]});
      wr_reg(8'hE2, {1'b0, pol, 6'h20});
      wr_reg(8'hE8, {4'h0, sel});
      rd_reg(8'hE8, 8'hFF, {4'h0, sel});
      if (ext) begin
         @(posedge clk);
         pin <= 1'b0;
         repeat (4) @(posedge clk);
         pin <= 1'b1;
      end else wr_reg(8'hE8, {4'h4, sel});
      wr_reg(8'hE8, {4'h4, sel});
      rd_reg(8'hE8, 8'hFF, {4'h4, sel});
      chk(ain_en, sel < 8 ? 9'h001 << sel : (sel == 4'hF ? 9'h100 : 9'h000));
      chk(pwr, 1'b1);
      for (i = 0; i < 700 && irq !== 1'b1; i = i + 1) @(posedge clk);
      chk(irq, 1'b1);
      chk(acq_n, st + 1);
      rd_reg(8'hE8, 8'hFF, {4'h8, sel});
      rd_reg(8'hC3, 8'hFF, lvl[9:2]);
      rd_reg(8'hC2, 8'h03, {6'h00, lvl[1:0]});
      rd_reg(8'hE2, 8'hFF, {1'b0, pol, 1'b1, (pol ? lvl < cmpv : lvl >= cmpv), 4'h0});
      rd_reg(8'hF4, 8'h01, 8'h01);
      @(posedge clk);
      chk(irq, 1'b0);
      wr_reg(8'hE8, {4'hC, sel});
      rd_reg(8'hE8, 8'hFF, {4'h8, sel});
      wr_reg(8'hE8, {4'h0, sel});
      rd_reg(8'hE8, 8'hFF, {4'h0, sel});
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(8'hE8, 8'hFF, 8'h00);
      rd_reg(8'hE1, 8'hFF, 8'h20);
      rd_reg(8'hE2, 8'hFF, 8'h00);
      rd_reg(8'hF2, 8'hFF, 8'h00);
      rd_reg(8'h00, 8'hFF, 8'h00);
      wr_reg(8'hF5, 8'h01);
      for (k = 0; k < 9; k = k + 1) begin
         seed = lfsr(seed);
         conv(k == 8 ? 4'hF : k[3:0], k < 2 ? {8{k[0]}} : {3'h0, seed[20:16]}, k == 5, k[0]);
      end
      // Masked completion must stay silent until unmasked
      wr_reg(8'hF5, 8'h00);
      wr_reg(8'hE8, 8'h41);
      repeat (100) @(posedge clk);
      chk(irq, 1'b0);
      wr_reg(8'hF5, 8'h01);
      @(posedge clk);
      chk(irq, 1'b1);
      rd_reg(8'hF4, 8'h01, 8'h01);
      wr_reg(8'hE8, 8'h08);
      // Routing register lags the select write by one edge
      repeat (2) @(posedge clk);
      chk(ain_en, 9'h000);
      wr_reg(8'hE8, 8'h0F);
      wr_reg(8'hE1, 8'h00);
      repeat (3) @(posedge clk);
      chk(ain_en, 9'h000);
      chk(pwr, 1'b0);
      repeat (3) @(posedge clk);
      end_of_test;
   end
endmodule // sadc_sequencer_bench
